//--- include/standby_pkg.sv
package standby_pkg;

  // ----------------------------------------------------------------
  // synchronised pin inputs
  // ----------------------------------------------------------------
  localparam int SYNC_W          = 5;
  localparam int SYN_EXT_RST_N   = 0;  // external_reset_input, low = reset
  localparam int SYN_MAIN_OK     = 1;  // main_core_supply above stand-by reference
  localparam int SYN_LVD_OK      = 2;  // main_core_supply above detector threshold
  localparam int SYN_LP_OSC_RUN  = 3;  // low-power oscillator running
  localparam int SYN_RTC_REF_LP  = 4;  // rtc reference is the low-power oscillator

  // value the sync chain shows during reset: pin in reset, supplies low
  localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 5'h00;

  // ----------------------------------------------------------------
  // reset values of the control state
  // ----------------------------------------------------------------
  localparam logic ENABLE_RST_VAL  = 1'b0;
  localparam logic FROZEN_RST_VAL  = 1'b1;
  localparam logic SUPPLY_RST_VAL  = 1'b1;  // 1 = ram on standby_core_supply
  localparam logic INTRST_RST_VAL  = 1'b1;
  localparam logic RTC_EN_RST_VAL  = 1'b0;
  localparam logic STBY_RST_VAL    = 1'b0;
  localparam logic CE_RST_VAL      = 1'b0;
  localparam logic WE_N_RST_VAL    = 1'b1;

  // ----------------------------------------------------------------
  // power sequencing states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_POWER_ON,
    ST_HELD,
    ST_RUN,
    ST_STANDBY
  } power_state_e;

endpackage

//--- include/ram_strobe_if.sv
`timescale 1ns/10ps

// ram strobes between the sequencer and the isolation stage
interface ram_strobe_if;
  logic frozen;     // interface freeze request
  logic ce_req;     // core chip enable, active high
  logic we_n_req;   // core write strobe, active low
  logic ce_out;     // isolated chip enable
  logic we_n_out;   // isolated write strobe

  modport core (output frozen, output ce_req, output we_n_req,
                input  ce_out, input  we_n_out);
  modport iso  (input  frozen, input  ce_req, input  we_n_req,
                output ce_out, output we_n_out);
endinterface

//--- logic/pin_sync.sv
`timescale 1ns/10ps

module pin_sync
  import standby_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [SYNC_W-1:0] async_in,
  output logic      [SYNC_W-1:0] sync_out
);

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;

  // ----------------------------------------------------------------
  // two-stage synchroniser per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      // first stage read only by second stage
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_r[i] <= SYNC_RST_VAL[i];
          sync_r[i] <= SYNC_RST_VAL[i];
        end else begin
          meta_r[i] <= async_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_r;

endmodule

//--- logic/ram_isolation.sv
`timescale 1ns/10ps

module ram_isolation
  import standby_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  ram_strobe_if.iso  strobes
);

  logic ce_nxt;
  logic we_n_nxt;
  logic ce_r;
  logic we_n_r;

  // ----------------------------------------------------------------
  // strobe blocking
  // ----------------------------------------------------------------
  // strobes blocked while frozen
  assign ce_nxt   = strobes.ce_req & ~strobes.frozen;
  assign we_n_nxt = strobes.we_n_req | strobes.frozen;

  always_ff @(posedge clk) begin
    if (rst) begin
      ce_r   <= CE_RST_VAL;
      we_n_r <= WE_N_RST_VAL;
    end else begin
      ce_r   <= ce_nxt;
      we_n_r <= we_n_nxt;
    end
  end

  assign strobes.ce_out   = ce_r;
  assign strobes.we_n_out = we_n_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_strobe_block_frozen: assert property (
    @(posedge clk) disable iff (rst)
    strobes.frozen |=> (we_n_r == 1'b1) && (ce_r == 1'b0))
    else $error("ram strobe passed while interface frozen");

endmodule

//--- logic/standby_ram_retention_control.sv
`timescale 1ns/10ps

// Summary of operation
// - clearing the stand-by ram enable freezes the retained ram interface at once.
// - the interface stays frozen until software sets the enable again after power-on.
// - while in reset the retained ram is disabled and its interface frozen.
// - a reset event moves the ram supply onto the stand-by core supply.
// - with the main supply below the stand-by reference and the enable clear the freeze holds.
// - the enable is honoured again only once the main supply is back above reference.
// - with the enable set, a main supply dip in normal running causes no freeze.
// - an isolation stage blocks ram strobes so a decaying write strobe cannot write.
// - leaving stand-by is the normal power-on sequence with the ram already retained.
// - at power-on the low-voltage detector holds reset until the core supply is up.
// - when internal reset ends the still-frozen ram goes back to the main supply.
// - in stand-by the rtc counts only when the low-power oscillator is its reference.

module standby_ram_retention_control
  import standby_pkg::*;
(
  input  wire logic CLOCK,
  input  wire logic SYS_RST,
  input  wire logic EXTERNAL_RESET_INPUT_N,
  input  wire logic MAIN_SUPPLY_ABOVE_REF,
  input  wire logic LVD_SUPPLY_OK,
  input  wire logic LP_OSC_RUNNING,
  input  wire logic RTC_REF_LP_OSC,
  input  wire logic ENABLE_SET_STB,
  input  wire logic ENABLE_CLR_STB,
  input  wire logic RAM_CE_REQ,
  input  wire logic RAM_WE_N_REQ,
  output logic      RAM_CE,
  output logic      RAM_WE_N,
  output logic      RAM_FROZEN,
  output logic      RAM_SUPPLY_STBY,
  output logic      INTERNAL_RESET,
  output logic      STANDBY_MODE,
  output logic      RTC_COUNT_EN,
  output logic      STANDBY_RAM_ENABLE
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_s;
  logic              ext_rst_n_s;
  logic              main_ok_s;
  logic              lvd_ok_s;
  logic              lp_osc_s;
  logic              rtc_ref_lp_s;

  logic              reset_int;
  logic              set_accept;
  logic              clr_accept;
  logic              stby_switch_hold;

  power_state_e      state_r;
  power_state_e      state_nxt;

  logic              enable_r;
  logic              enable_nxt;
  logic              frozen_r;
  logic              frozen_nxt;
  logic              supply_stby_r;
  logic              supply_stby_nxt;
  logic              int_reset_r;
  logic              rtc_en_r;
  logic              rtc_en_nxt;
  logic              standby_r;
  logic              standby_nxt;

  ram_strobe_if      strobes ();

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  // reset pin assumed glitch-free low during supply ramps
  assign pins_async[SYN_EXT_RST_N]  = EXTERNAL_RESET_INPUT_N;
  assign pins_async[SYN_MAIN_OK]    = MAIN_SUPPLY_ABOVE_REF;
  assign pins_async[SYN_LVD_OK]     = LVD_SUPPLY_OK;
  assign pins_async[SYN_LP_OSC_RUN] = LP_OSC_RUNNING;
  assign pins_async[SYN_RTC_REF_LP] = RTC_REF_LP_OSC;

  pin_sync u_pin_sync (
    .clk      (CLOCK),
    .rst      (SYS_RST),
    .async_in (pins_async),
    .sync_out (pins_s)
  );

  assign ext_rst_n_s  = pins_s[SYN_EXT_RST_N];
  assign main_ok_s    = pins_s[SYN_MAIN_OK];
  assign lvd_ok_s     = pins_s[SYN_LVD_OK];
  assign lp_osc_s     = pins_s[SYN_LP_OSC_RUN];
  assign rtc_ref_lp_s = pins_s[SYN_RTC_REF_LP];

  // ----------------------------------------------------------------
  // internal reset
  // ----------------------------------------------------------------
  // detector holds reset while core supply low
  assign reset_int = SYS_RST | ~lvd_ok_s | ~ext_rst_n_s;

  // ----------------------------------------------------------------
  // enable bit decode
  // ----------------------------------------------------------------
  // set honoured only with main supply above reference
  assign set_accept = ENABLE_SET_STB & main_ok_s & ~reset_int;
  assign clr_accept = ENABLE_CLR_STB & ~reset_int;

  // enable cleared by any reset, set beats clear
  assign enable_nxt = reset_int  ? ENABLE_RST_VAL :
                      set_accept ? 1'b1 :
                      clr_accept ? 1'b0 :
                      enable_r;

  // ----------------------------------------------------------------
  // freeze decision
  // ----------------------------------------------------------------
  // switching circuit holds freeze while supply low and bit not set
  // with the bit set a supply dip does not freeze
  assign stby_switch_hold = ~main_ok_s & ~enable_r;

  // freeze follows the cleared bit at once
  // release only through a new set
  assign frozen_nxt = reset_int | ~enable_nxt | stby_switch_hold;

  // ----------------------------------------------------------------
  // ram supply selection
  // ----------------------------------------------------------------
  // reset moves ram onto standby supply
  // end of internal reset returns ram to main supply
  assign supply_stby_nxt = reset_int;

  // ----------------------------------------------------------------
  // power state decode
  // ----------------------------------------------------------------
  // leaving standby walks the normal power-on path
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POWER_ON: begin
        if (lvd_ok_s) begin
          state_nxt = ST_HELD;
        end
      end
      ST_HELD: begin
        if (!lvd_ok_s) begin
          state_nxt = ST_POWER_ON;
        end else if (!main_ok_s) begin
          state_nxt = ST_STANDBY;
        end else if (!reset_int) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (reset_int) begin
          state_nxt = ST_HELD;
        end
      end
      ST_STANDBY: begin
        if (!lvd_ok_s) begin
          state_nxt = ST_POWER_ON;
        end else if (main_ok_s) begin
          state_nxt = ST_HELD;
        end
      end
      default: begin
        state_nxt = ST_POWER_ON;
      end
    endcase
  end

  assign standby_nxt = (state_nxt == ST_STANDBY) | (state_nxt == ST_POWER_ON);

  // ----------------------------------------------------------------
  // rtc count gating
  // ----------------------------------------------------------------
  // only the low-power oscillator keeps rtc alive in standby
  assign rtc_en_nxt = standby_nxt ? (rtc_ref_lp_s & lp_osc_s) : 1'b1;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_r <= ST_POWER_ON;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      enable_r      <= ENABLE_RST_VAL;
      frozen_r      <= FROZEN_RST_VAL;
      supply_stby_r <= SUPPLY_RST_VAL;
    end else begin
      enable_r      <= enable_nxt;
      frozen_r      <= frozen_nxt;
      supply_stby_r <= supply_stby_nxt;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      int_reset_r <= INTRST_RST_VAL;
      rtc_en_r    <= RTC_EN_RST_VAL;
      standby_r   <= STBY_RST_VAL;
    end else begin
      int_reset_r <= reset_int;
      rtc_en_r    <= rtc_en_nxt;
      standby_r   <= standby_nxt;
    end
  end

  // ----------------------------------------------------------------
  // strobe isolation stage
  // ----------------------------------------------------------------
  // frozen state gates core strobes
  assign strobes.frozen   = frozen_r;
  assign strobes.ce_req   = RAM_CE_REQ;
  assign strobes.we_n_req = RAM_WE_N_REQ;

  ram_isolation u_ram_isolation (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .strobes (strobes.iso)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RAM_CE             = strobes.ce_out;
  assign RAM_WE_N           = strobes.we_n_out;
  assign RAM_FROZEN         = frozen_r;
  assign RAM_SUPPLY_STBY    = supply_stby_r;
  assign INTERNAL_RESET     = int_reset_r;
  assign STANDBY_MODE       = standby_r;
  assign RTC_COUNT_EN       = rtc_en_r;
  assign STANDBY_RAM_ENABLE = enable_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_reset_release;
    reset_int ##1 !reset_int;
  endsequence

  sequence s_clear_while_enabled;
    enable_r && clr_accept && !set_accept;
  endsequence

  a_clear_freezes_now: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    s_clear_while_enabled |=> frozen_r && !enable_r)
    else $error("clearing the enable did not freeze ram");

  a_frozen_until_set: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    frozen_r && !set_accept |=> frozen_r)
    else $error("ram unfroze without a set of the enable");

  a_reset_freezes_ram: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    reset_int |=> frozen_r && !enable_r ##1 !RAM_CE && RAM_WE_N)
    else $error("ram not frozen and disabled in reset");

  a_reset_supply_stby: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    reset_int |=> supply_stby_r)
    else $error("reset did not move ram to standby supply");

  a_low_supply_freeze: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    !main_ok_s && !enable_r |=> frozen_r)
    else $error("freeze dropped with main supply low");

  a_set_needs_supply: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    !enable_r && !main_ok_s |=> !enable_r)
    else $error("enable taken with main supply below reference");

  a_dip_keeps_access: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    enable_r && !reset_int && !main_ok_s && !clr_accept |=> !frozen_r)
    else $error("supply dip froze an enabled ram");

  a_lvd_holds_reset: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    !lvd_ok_s |=> INTERNAL_RESET && RAM_SUPPLY_STBY)
    else $error("internal reset released with core supply low");

  a_release_main_supply: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    s_reset_release |=> !supply_stby_r && frozen_r)
    else $error("ram not back on main supply after reset");

  a_rtc_standby_gate: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    (state_nxt == ST_STANDBY) && !rtc_ref_lp_s |=> !RTC_COUNT_EN)
    else $error("rtc counting in standby without low-power reference");

  a_standby_exit_path: assert property (
    @(posedge CLOCK) disable iff (SYS_RST)
    (state_r == ST_STANDBY) |=> (state_r != ST_RUN))
    else $error("standby left without the power-on path");

endmodule

//--- tb/power_partner.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// external reset driver and supply circuitry
// ----------------------------------------------------------------
module power_partner (
  input  wire logic clk,
  output logic      ext_rst_n,
  output logic      main_ok,
  output logic      lvd_ok,
  output logic      lp_osc_run,
  output logic      rtc_ref_lp
);
  // board starts unpowered with the reset pin low
  initial begin
    ext_rst_n  = 1'b0;
    main_ok    = 1'b0;
    lvd_ok     = 1'b0;
    lp_osc_run = 1'b0;
    rtc_ref_lp = 1'b0;
  end

  // pins move just after a rising edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic power_down();
    ext_rst_n = 1'b0;
    wait_cyc(4);
    main_ok = 1'b0;
    wait_cyc(2);
    lvd_ok = 1'b0;
  endtask

  task automatic power_up(input bit lvd_late);
    main_ok = 1'b1;
    wait_cyc(2);
    lvd_ok = !lvd_late;
    wait_cyc(4);
    ext_rst_n = 1'b1;
  endtask

  // detector output, used for a late core supply
  task automatic set_lvd(input logic v);
    lvd_ok = v;
  endtask

  // main supply dip during running
  task automatic set_main(input logic v);
    main_ok = v;
  endtask

  // rtc reference and low-power oscillator state
  task automatic set_rtc(input logic ref_lp, input logic osc);
    rtc_ref_lp = ref_lp;
    lp_osc_run = osc;
  endtask
endmodule

//--- tb/standby_ram_retention_control_tb.sv
`timescale 1ns/10ps

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s expected %b seen %b", nm, ex, got); end end

module standby_ram_retention_control_tb;
  import standby_pkg::*;

  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic set_stb = 1'b0;
  logic clr_stb = 1'b0;
  logic ce_req = 1'b0;
  logic we_n_req = 1'b1;
  logic ext_rst_n, main_ok, lvd_ok, lp_osc_run, rtc_ref_lp;
  logic ram_ce, ram_we_n, ram_frozen, supply_stby;
  logic internal_reset, standby_mode, rtc_count_en, ram_enable;
  int   n_mismatch = 0;
  int   compares = 0;

  // 100 MHz core clock
  always #5 clock = ~clock;

  power_partner PWR (
    .clk        (clock),
    .ext_rst_n  (ext_rst_n),
    .main_ok    (main_ok),
    .lvd_ok     (lvd_ok),
    .lp_osc_run (lp_osc_run),
    .rtc_ref_lp (rtc_ref_lp)
  );

  standby_ram_retention_control DUT (
    .CLOCK                  (clock),
    .SYS_RST                (sys_rst),
    .EXTERNAL_RESET_INPUT_N (ext_rst_n),
    .MAIN_SUPPLY_ABOVE_REF  (main_ok),
    .LVD_SUPPLY_OK          (lvd_ok),
    .LP_OSC_RUNNING         (lp_osc_run),
    .RTC_REF_LP_OSC         (rtc_ref_lp),
    .ENABLE_SET_STB         (set_stb),
    .ENABLE_CLR_STB         (clr_stb),
    .RAM_CE_REQ             (ce_req),
    .RAM_WE_N_REQ           (we_n_req),
    .RAM_CE                 (ram_ce),
    .RAM_WE_N               (ram_we_n),
    .RAM_FROZEN             (ram_frozen),
    .RAM_SUPPLY_STBY        (supply_stby),
    .INTERNAL_RESET         (internal_reset),
    .STANDBY_MODE           (standby_mode),
    .RTC_COUNT_EN           (rtc_count_en),
    .STANDBY_RAM_ENABLE     (ram_enable)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // bounded wait for the internal reset level
  task automatic wait_rst(input logic v);
    int i;
    i = 0;
    while (internal_reset !== v && i < 30) begin
      tick(1);
      i++;
    end
    if (internal_reset !== v) begin
      n_mismatch++;
      $display("[FAIL] internal_reset expected %b seen %b", v, internal_reset);
      test_done();
    end
  endtask

  // one-cycle software strobe on the enable bit
  task automatic strobe(input bit set);
    if (set) begin
      set_stb = 1'b1;
      tick(1);
      set_stb = 1'b0;
    end else begin
      clr_stb = 1'b1;
      tick(1);
      clr_stb = 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    `CHK("ram_ce", 1'b0, ram_ce)
    `CHK("ram_we_n", 1'b1, ram_we_n)
    `CHK("ram_frozen", 1'b1, ram_frozen)
    `CHK("supply_stby", 1'b1, supply_stby)
    `CHK("internal_reset", 1'b1, internal_reset)
    `CHK("ram_enable", 1'b0, ram_enable)
  endtask

  // power-on, optionally with the core supply late
  task automatic t_power_up(input bit lvd_late);
    PWR.power_up(lvd_late);
    if (lvd_late) begin
      tick(10);
      `CHK("internal_reset lvd", 1'b1, internal_reset)
      strobe(1'b1);
      `CHK("ram_enable held", 1'b0, ram_enable)
      PWR.set_lvd(1'b1);
    end
    `CHK("supply_stby held", 1'b1, supply_stby)
    wait_rst(1'b0);
    `CHK("ram_frozen exit", 1'b1, ram_frozen)
    `CHK("supply_stby exit", 1'b0, supply_stby)
    tick(1);
    `CHK("supply_stby main", 1'b0, supply_stby)
    `CHK("standby_mode run", 1'b0, standby_mode)
    `CHK("ram_enable exit", 1'b0, ram_enable)
    `CHK("rtc_count_en run", 1'b1, rtc_count_en)
  endtask

  // enable, access, clear, blocked access
  task automatic t_enable_access();
    strobe(1'b1);
    `CHK("ram_enable set", 1'b1, ram_enable)
    `CHK("ram_frozen set", 1'b0, ram_frozen)
    ce_req = 1'b1;
    we_n_req = 1'b0;
    tick(1);
    `CHK("ram_ce pass", 1'b1, ram_ce)
    `CHK("ram_we_n pass", 1'b0, ram_we_n)
    strobe(1'b0);
    `CHK("ram_enable clr", 1'b0, ram_enable)
    `CHK("ram_frozen clr", 1'b1, ram_frozen)
    tick(1);
    `CHK("ram_ce block", 1'b0, ram_ce)
    `CHK("ram_we_n block", 1'b1, ram_we_n)
    ce_req = 1'b0;
    we_n_req = 1'b1;
  endtask

  // main supply dip with the bit set, then clear
  task automatic t_dip();
    strobe(1'b1);
    PWR.set_main(1'b0);
    tick(8);
    `CHK("ram_frozen dip", 1'b0, ram_frozen)
    `CHK("ram_enable dip", 1'b1, ram_enable)
    strobe(1'b0);
    `CHK("ram_frozen dip clr", 1'b1, ram_frozen)
    tick(1);
    strobe(1'b1);
    `CHK("ram_enable low supply", 1'b0, ram_enable)
    tick(3);
    `CHK("ram_frozen low supply", 1'b1, ram_frozen)
    PWR.set_main(1'b1);
    tick(4);
    strobe(1'b1);
    `CHK("ram_frozen supply back", 1'b0, ram_frozen)
    tick(1);
    strobe(1'b0);
  endtask

  // enter stand-by and sweep the rtc reference
  task automatic t_standby();
    strobe(1'b1);
    ce_req = 1'b1;
    we_n_req = 1'b0;
    PWR.power_down();
    wait_rst(1'b1);
    tick(1);
    `CHK("supply_stby entry", 1'b1, supply_stby)
    `CHK("ram_frozen entry", 1'b1, ram_frozen)
    `CHK("ram_enable entry", 1'b0, ram_enable)
    `CHK("ram_we_n entry", 1'b1, ram_we_n)
    `CHK("ram_ce entry", 1'b0, ram_ce)
    tick(6);
    `CHK("standby_mode", 1'b1, standby_mode)
    for (int i = 0; i < 4; i++) begin
      PWR.set_rtc(i[1], i[0]);
      tick(4);
      `CHK("rtc_count_en stby", i[1] & i[0], rtc_count_en)
    end
    ce_req = 1'b0;
    we_n_req = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(3);
    t_reset_values();
    tick(1);
    sys_rst = 1'b0;
    t_power_up(1'b0);
    t_enable_access();
    t_dip();
    t_standby();
    t_power_up(1'b1);
    t_enable_access();
    test_done();
  end
endmodule
